// ===== pkg/crs_consts.vh
// Constants for the completer request stream output block.
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_DATA_W 256
`define CRS_KEEP_W 8
`define CRS_USER_W 85
`define CRS_LEN_W 11
`define CRS_CREDIT_W 6
`define CRS_CREDIT_MAX 6'h20
`define CRS_WIDTH_64 64
`define CRS_WIDTH_128 128
`define CRS_WIDTH_256 256
`define CRS_KEEP_MASK_64 8'h03
`define CRS_KEEP_MASK_128 8'h0F
`define CRS_KEEP_MASK_256 8'hFF
`define CRS_BEAT_DW_64 11'h002
`define CRS_BEAT_DW_128 11'h004
`define CRS_BEAT_DW_256 11'h008
`endif

// ===== core/crs_credit_counter.v
// Saturating non-posted credit counter.
`timescale 1ns/100ps
`include "crs_consts.vh"
module crs_credit_counter (
   input wire clk,
   input wire rst_n,
   input wire credit_request,
   input wire credit_consume,
   output reg [`CRS_CREDIT_W-1:0] level,
   output wire nonzero
);
   wire inc;
   wire dec;
   reg [`CRS_CREDIT_W-1:0] next_level;

   assign inc = credit_request && (level != `CRS_CREDIT_MAX);
   assign dec = credit_consume && (level != {`CRS_CREDIT_W{1'b0}});
   assign nonzero = (level != {`CRS_CREDIT_W{1'b0}});

   always @* begin
      next_level = level;
      if (inc && !dec) begin
         next_level = level + 6'h01;
      end else if (dec && !inc) begin
         next_level = level - 6'h01;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         level <= {`CRS_CREDIT_W{1'b0}};
      end else begin
         level <= next_level;
      end
   end
endmodule

// ===== core/crs_request_stream_out.v
// Completer request stream output stage with non-posted credit gating.
`timescale 1ns/100ps
`include "crs_consts.vh"
module crs_request_stream_out #(
   parameter BUS_WIDTH = 256
) (
   input wire clk,
   input wire rst_n,
   input wire posted_valid,
   output wire posted_ready,
   input wire [`CRS_DATA_W-1:0] posted_data,
   input wire [`CRS_LEN_W-1:0] posted_len_dw,
   input wire [`CRS_USER_W-1:0] posted_sideband,
   input wire nonposted_valid,
   output wire nonposted_ready,
   input wire [`CRS_DATA_W-1:0] nonposted_data,
   input wire [`CRS_LEN_W-1:0] nonposted_len_dw,
   input wire [`CRS_USER_W-1:0] nonposted_sideband,
   output reg [`CRS_DATA_W-1:0] request_stream_data_bus,
   output reg [`CRS_USER_W-1:0] request_sideband_word,
   output reg request_end_of_packet,
   output reg [`CRS_KEEP_W-1:0] request_dword_keep,
   output reg request_stream_valid,
   input wire request_stream_ready,
   input wire nonposted_credit_request,
   output wire [`CRS_CREDIT_W-1:0] nonposted_credit_level
);
   // Dwords carried by one beat at the configured width.
   localparam [`CRS_LEN_W-1:0] DW_PER_BEAT =
      (BUS_WIDTH == `CRS_WIDTH_64) ? `CRS_BEAT_DW_64 :
      (BUS_WIDTH == `CRS_WIDTH_128) ? `CRS_BEAT_DW_128 : `CRS_BEAT_DW_256;
   localparam [`CRS_KEEP_W-1:0] CFG_KEEP_MASK =
      (BUS_WIDTH == `CRS_WIDTH_64) ? `CRS_KEEP_MASK_64 :
      (BUS_WIDTH == `CRS_WIDTH_128) ? `CRS_KEEP_MASK_128 : `CRS_KEEP_MASK_256;

   // Stream state: between packets, or inside a posted or a non-posted packet.
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_POSTED = 2'h1;
   localparam [1:0] ST_NONPOSTED = 2'h2;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [`CRS_LEN_W-1:0] rem;
   reg [`CRS_LEN_W-1:0] next_rem;
   reg next_stream_valid;
   reg [`CRS_DATA_W-1:0] next_data_bus;
   reg [`CRS_USER_W-1:0] next_sideband;
   reg next_end_of_packet;
   reg [`CRS_KEEP_W-1:0] next_dword_keep;
   wire busy;

   wire credit_nonzero;
   wire load;
   wire start_p;
   wire start_np;
   reg use_np;
   reg src_valid;
   wire take;
   wire np_deliver;
   wire [`CRS_LEN_W-1:0] head_len;
   wire [`CRS_LEN_W-1:0] len_now;
   wire beat_last;
   wire [`CRS_DATA_W-1:0] src_data;
   wire [`CRS_USER_W-1:0] src_user;
   wire [`CRS_DATA_W-1:0] next_data;
   wire [`CRS_KEEP_W-1:0] next_keep;

   crs_credit_counter u_credit (
      .clk(clk),
      .rst_n(rst_n),
      .credit_request(nonposted_credit_request),
      .credit_consume(np_deliver),
      .level(nonposted_credit_level),
      .nonzero(credit_nonzero)
   );

   // Packet state decoded once for the steering below.
   assign busy = (state != ST_IDLE);

   // The output register may take a new beat when empty or when its beat leaves now.
   assign load = !request_stream_valid || request_stream_ready;

   // Packet choice happens only between packets; posted traffic is never held by credit.
   assign start_p = !busy && posted_valid;
   assign start_np = !busy && !posted_valid && nonposted_valid && credit_nonzero;

   // Inside a packet its owner keeps the stream until the last beat is taken.
   always @* begin
      use_np = 1'b0;
      src_valid = 1'b0;
      case (state)
         ST_IDLE: begin
            use_np = start_np;
            src_valid = start_p || start_np;
         end
         ST_POSTED: begin
            src_valid = posted_valid;
         end
         ST_NONPOSTED: begin
            use_np = 1'b1;
            src_valid = nonposted_valid;
         end
         default: begin
            src_valid = 1'b0;
         end
      endcase
   end

   // Nothing is taken from a source while reset holds the stage empty, so no beat is lost.
   assign take = load && src_valid && rst_n;
   assign posted_ready = take && !use_np;
   assign nonposted_ready = take && use_np;
   assign np_deliver = take && start_np;

   // A zero length is treated as one Dword so a packet always ends.
   assign head_len = use_np ? nonposted_len_dw : posted_len_dw;
   assign len_now = busy ? rem :
      ((head_len == {`CRS_LEN_W{1'b0}}) ? 11'h001 : head_len);
   assign beat_last = (len_now <= DW_PER_BEAT);
   assign src_data = use_np ? nonposted_data : posted_data;
   assign src_user = use_np ? nonposted_sideband : posted_sideband;

   genvar i;
   generate
      for (i = 0; i < `CRS_KEEP_W; i = i + 1) begin : g_dword
         // Contiguous keep from Dword 0; within the configured width only a short final beat has trailing zeros.
         assign next_keep[i] = CFG_KEEP_MASK[i] &&
            (!beat_last || (len_now > i));
         assign next_data[32*i+31:32*i] =
            src_data[32*i+31:32*i] & {32{CFG_KEEP_MASK[i]}};
      end
   endgenerate

   // A packet leaves the idle state only when its first beat is not also its last.
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take && !beat_last) begin
               if (use_np) begin
                  next_state = ST_NONPOSTED;
               end else begin
                  next_state = ST_POSTED;
               end
            end
         end
         ST_POSTED: begin
            if (take && beat_last) begin
               next_state = ST_IDLE;
            end
         end
         ST_NONPOSTED: begin
            if (take && beat_last) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Dwords still owed after the beat being taken; stale once the last beat has gone.
   always @* begin
      next_rem = rem;
      if (take) begin
         next_rem = len_now - DW_PER_BEAT;
      end
   end

   // Outputs refill only when the stage is empty or its beat leaves, so a stalled
   // receiver sees every field hold.
   always @* begin
      next_stream_valid = request_stream_valid;
      next_data_bus = request_stream_data_bus;
      next_sideband = request_sideband_word;
      next_end_of_packet = request_end_of_packet;
      next_dword_keep = request_dword_keep;
      if (load) begin
         next_stream_valid = src_valid;
      end
      if (take) begin
         next_data_bus = next_data;
         next_sideband = src_user;
         next_end_of_packet = beat_last;
         next_dword_keep = next_keep;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_stream_valid <= 1'b0;
      end else begin
         request_stream_valid <= next_stream_valid;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_stream_data_bus <= {`CRS_DATA_W{1'b0}};
      end else begin
         request_stream_data_bus <= next_data_bus;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_sideband_word <= {`CRS_USER_W{1'b0}};
      end else begin
         request_sideband_word <= next_sideband;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_end_of_packet <= 1'b0;
      end else begin
         request_end_of_packet <= next_end_of_packet;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_dword_keep <= {`CRS_KEEP_W{1'b0}};
      end else begin
         request_dword_keep <= next_dword_keep;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         rem <= {`CRS_LEN_W{1'b0}};
      end else begin
         rem <= next_rem;
      end
   end
endmodule

// ===== verif/crs_sva.sv
// Assertion checker for the request stream output stage.
`timescale 1ns/100ps
`include "crs_consts.vh"
module crs_sva #(parameter BUS_WIDTH = 256) (
   input wire clk,
   input wire rst_n,
   input wire [`CRS_DATA_W-1:0] request_stream_data_bus,
   input wire [`CRS_USER_W-1:0] request_sideband_word,
   input wire request_end_of_packet,
   input wire [`CRS_KEEP_W-1:0] request_dword_keep,
   input wire request_stream_valid,
   input wire request_stream_ready,
   input wire nonposted_credit_request,
   input wire [`CRS_CREDIT_W-1:0] nonposted_credit_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence stall_s;
      request_stream_valid && !request_stream_ready;
   endsequence
   sequence held_s;
      request_stream_valid && $stable(request_stream_data_bus) && $stable(request_dword_keep)
         && $stable(request_end_of_packet) && $stable(request_sideband_word);
   endsequence
   stall_hold_a: assert property (stall_s |=> held_s) else $error("stall not held");
   data_upper_a: assert property ((request_stream_data_bus >> BUS_WIDTH) == 0)
      else $error("upper data set");
   keep_upper_a: assert property ((request_dword_keep >> (BUS_WIDTH / 32)) == 0)
      else $error("upper keep set");
   keep_run_a: assert property (request_stream_valid |-> request_dword_keep[0]
      && ((request_dword_keep + 8'h01) & request_dword_keep) == 0) else $error("keep gap");
   keep_full_a: assert property (request_stream_valid && !request_end_of_packet
      |-> request_dword_keep + 8'h01 == 9'h001 << (BUS_WIDTH / 32)) else $error("keep short");
   packet_hold_a: assert property (request_stream_valid && !request_end_of_packet
      |=> request_stream_valid) else $error("valid dropped in packet");
   reset_idle_a: assert property ($rose(rst_n) |-> !request_stream_valid)
      else $error("valid out of reset");
   credit_cap_a: assert property (nonposted_credit_level <= `CRS_CREDIT_MAX)
      else $error("credit over limit");
   credit_rise_a: assert property (!$past(nonposted_credit_request)
      |-> nonposted_credit_level <= $past(nonposted_credit_level)) else $error("credit rose");
endmodule
bind crs_request_stream_out crs_sva #(.BUS_WIDTH(BUS_WIDTH)) i_crs_sva (.clk, .rst_n,
   .request_stream_data_bus, .request_sideband_word, .request_end_of_packet,
   .request_dword_keep, .request_stream_valid, .request_stream_ready,
   .nonposted_credit_request, .nonposted_credit_level);

// ===== verif/crs_user_model.sv
// User-side model that paces the request stream and grants credits.
`timescale 1ns/100ps
module crs_user_model (
   input wire clk,
   input wire slow,
   input wire give,
   output reg ready = 1'b0,
   output reg credit_req = 1'b0
);
   reg [1:0] phase = 2'h0;
   always @(posedge clk) begin
      phase <= phase + 2'h1;
      ready <= #1 !slow || phase == 2'h3;
      credit_req <= #1 give;
   end
endmodule

// ===== verif/tb.sv
// Testbench for the request stream output stage.
`timescale 1ns/100ps
module tb;
   reg clk = 1'b0, rst_n = 1'b0, pv = 1'b0, nv = 1'b0, slow = 1'b0, give = 1'b0;
   reg [63:0] seq = 64'h0, rx = 64'h0;
   reg [10:0] len = 11'h001;
   integer fails = 0, n_tests = 0, left = 0, q[$];
   wire pr, nr, vld, rdy, last, creq;
   wire [255:0] dat;
   wire [84:0] sb;
   wire [7:0] keep;
   wire [5:0] lvl;
   always #2.5 clk = !clk;
   crs_request_stream_out #(.BUS_WIDTH(64)) i_crs_request_stream_out (.clk(clk), .rst_n(rst_n),
      .posted_valid(pv), .posted_ready(pr), .posted_data({4{seq}}), .posted_len_dw(len),
      .posted_sideband({21'h0, seq}), .nonposted_valid(nv), .nonposted_ready(nr),
      .nonposted_data({4{seq}}), .nonposted_len_dw(len), .nonposted_sideband({21'h0, seq}),
      .request_stream_data_bus(dat), .request_sideband_word(sb), .request_end_of_packet(last),
      .request_dword_keep(keep), .request_stream_valid(vld), .request_stream_ready(rdy),
      .nonposted_credit_request(creq), .nonposted_credit_level(lvl));
   crs_user_model i_crs_user_model (.clk(clk), .slow(slow), .give(give), .ready(rdy),
      .credit_req(creq));
   task check(input [63:0] nm, input [84:0] e, input [84:0] g);
      begin
         n_tests = n_tests + 1;
         if (e !== g) begin
            fails = fails + 1;
            $display("unexpected %0s: expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d fails %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   always @(negedge clk) begin
      if (vld && rdy) begin
         if (left == 0) left = q.pop_front();
         check("keep", left > 1 ? 8'h03 : 8'h01, keep);
         check("last", left <= 2, last);
         check("data", rx, dat[63:0]);
         check("side", rx, sb);
         left = left > 2 ? left - 2 : 0;
         rx = rx + 1;
      end
   end
   task send(input np, input integer n);
      integer b, k;
      begin
         @(posedge clk);
         #1 len = n;
         q.push_back(n);
         pv = !np;
         nv = np;
         for (b = 0; b < (n + 1) / 2; b = b + 1) begin
            k = 0;
            @(negedge clk);
            while (!(np ? nr : pr) && k < 300) begin
               @(negedge clk);
               k = k + 1;
            end
            if (k == 300) begin
               fails = fails + 1;
               finish_test;
            end
            @(posedge clk);
            #1 seq = seq + 1;
         end
         pv = 1'b0;
         nv = 1'b0;
      end
   endtask
   task t_pkts;
      begin
         send(0, 3);
         send(0, 1);
         slow = 1'b1;
         send(0, 4);
         send(0, 5);
         slow = 1'b0;
      end
   endtask
   task t_reset;
      begin
         @(posedge clk) #1 give = 1'b1;
         repeat (3) @(posedge clk);
         #1 give = 1'b0;
         rst_n = 1'b0;
         pv = 1'b1;
         repeat (3) @(negedge clk) begin
            check("rvalid", 0, vld);
            check("rready", 0, pr);
         end
         @(posedge clk) #1 rst_n = 1'b1;
         pv = 1'b0;
         @(posedge clk) #1 check("rcredit", 0, lvl);
      end
   endtask
   task t_credit;
      begin
         nv = 1'b1;
         repeat (10) @(negedge clk) check("np_ready", 0, nr);
         @(posedge clk) #1 nv = 1'b0;
         give = 1'b1;
         @(posedge clk) #1 give = 1'b0;
         repeat (3) @(posedge clk);
         check("credit", 1, lvl);
         send(1, 3);
         check("credit", 0, lvl);
      end
   endtask
   task t_sat;
      begin
         give = 1'b1;
         repeat (40) @(posedge clk);
         #1 give = 1'b0;
         repeat (3) @(posedge clk);
         check("credit", 32, lvl);
         send(1, 2);
         check("credit", 31, lvl);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_pkts;
      t_reset;
      t_credit;
      t_sat;
      repeat (20) @(posedge clk);
      check("pending", 0, q.size() + left);
      finish_test;
   end
endmodule
